// ===== bim_defines.vh
// constants for the battery impedance measurement sequencer
`ifndef BIM_DEFINES_VH
`define BIM_DEFINES_VH
`define BIM_ADDR_TIMING     8'h0d
`define BIM_ADDR_CONFIG     8'h0e
`define BIM_ADDR_SUPPLY     8'h0f
`define BIM_ADDR_OPEN       8'h10
`define BIM_ADDR_LOADED     8'h11
`define BIM_CFG_ACTIVE      7
`define BIM_CFG_ABORT       6
`define BIM_CFG_DLYSKIP     3
`define BIM_CUR_HI          2
`define BIM_TM_SKIP         2'h0
`define BIM_TM_NOW          2'h1
`define BIM_TM_SHORT        2'h2
`define BIM_TM_LONG         2'h3
`define BIM_CUR_RESERVED    3'h7
`define BIM_CUR_NONE        3'h0
`define BIM_STEP_SUPPLY     2'h0
`define BIM_STEP_OPEN       2'h1
`define BIM_STEP_LOADED     2'h2
`define BIM_SKIP_CODE       8'h00
`define BIM_ABORT_CODE      8'hff
`define BIM_ZERO8           8'h00
`define BIM_CLK_KHZ         20000
`define BIM_DLY_SHORT_MS    10
`define BIM_DLY_LONG_MS     100
`define BIM_CNT_W           21
`define BIM_SHORT_CYCLES    21'h30d40
`define BIM_LONG_CYCLES     21'h1e8480
`endif

// ===== bim_delay_timer.v
// step delay counter of the measurement sequencer
`timescale 1ns/1ps
`include "bim_defines.vh"
module bim_delay_timer (
    input  wire                  ref_clk_i,
    input  wire                  rstn_i,
    input  wire                  load_i,
    input  wire                  cancel_i,
    input  wire [`BIM_CNT_W-1:0] cycles_i,
    output wire                  expired_o
);
    reg [`BIM_CNT_W-1:0] count;
    reg                  running;

    assign expired_o = running && (count == {`BIM_CNT_W{1'b0}});

    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count   <= {`BIM_CNT_W{1'b0}};
            running <= 1'b0;
        end else if (cancel_i) begin
            running <= 1'b0;
        end else if (load_i) begin
            count   <= cycles_i - {{(`BIM_CNT_W-1){1'b0}}, 1'b1};
            running <= 1'b1;
        end else if (expired_o) begin
            running <= 1'b0;
        end else if (running) begin
            count <= count - {{(`BIM_CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // bim_delay_timer

// ===== bim_sequencer.v
// battery impedance measurement sequencer with its register file
// Contract
// R1: per step 2-bit timing: skip, take now, take after 10ms, after 100ms.
// R2: writing one to measurement_active starts sequence with programmed timings and current.
// R3: a start written while a sequence runs is ignored.
// R4: measurement_active reads one throughout the sequence, zero once finished.
// R5: load_current_select 000 none, 001..110 250uA..8mA, 111 reserved.
// R6: writing one to measurement_abort stops sequence at once and reports abort.
`timescale 1ns/1ps
`include "bim_defines.vh"
module bim_sequencer #(
    parameter [`BIM_CNT_W-1:0] SHORT_CYCLES = `BIM_SHORT_CYCLES,
    parameter [`BIM_CNT_W-1:0] LONG_CYCLES  = `BIM_LONG_CYCLES
) (
    input  wire       ref_clk_i,
    input  wire       rstn_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    output reg  [7:0] reg_rdata_o,
    output reg        conv_start_o,
    output reg  [1:0] conv_step_o,
    input  wire       conv_done_i,
    input  wire [7:0] conv_data_i,
    output reg  [2:0] load_current_o,
    output reg        load_enable_o,
    output wire       measuring_o
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EVAL = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    localparam [1:0] ST_CONV = 2'h3;

    reg [1:0] state;
    reg [1:0] step;
    reg [5:0] step_timing;
    reg [5:0] run_timing;
    reg [2:0] load_current_select;
    reg [2:0] run_current;
    reg       dly_skip;
    reg       aborted;
    reg [7:0] supply_result_code;
    reg [7:0] open_result_code;
    reg [7:0] loaded_result_code;

    reg [1:0]            cur_tm;
    reg [`BIM_CNT_W-1:0] dly_cycles;
    wire                 dly_expired;
    wire                 measurement_active;
    wire                 cfg_wr;
    wire                 start_req;
    wire                 abort_req;
    reg                  tmr_load;

    assign measurement_active = (state != ST_IDLE);
    assign measuring_o        = measurement_active;
    assign cfg_wr    = reg_wr_i && (reg_addr_i == `BIM_ADDR_CONFIG);
    assign abort_req = cfg_wr && reg_wdata_i[`BIM_CFG_ABORT];
    // R3: start ignored while running
    assign start_req = cfg_wr && reg_wdata_i[`BIM_CFG_ACTIVE] && !measurement_active
                       && !abort_req;

    // timing field of the step in hand
    always @* begin
        case (step)
            `BIM_STEP_SUPPLY: cur_tm = run_timing[5:4];
            `BIM_STEP_OPEN:   cur_tm = run_timing[3:2];
            default:          cur_tm = run_timing[1:0];
        endcase
        // R1: delay per timing code
        if (cur_tm == `BIM_TM_LONG) begin
            dly_cycles = LONG_CYCLES;
        end else begin
            dly_cycles = SHORT_CYCLES;
        end
        tmr_load = (state == ST_EVAL) && (cur_tm != `BIM_TM_SKIP)
                   && (cur_tm != `BIM_TM_NOW) && !abort_req;
    end

    bim_delay_timer u_timer (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .load_i    (tmr_load),
        .cancel_i  (abort_req),
        .cycles_i  (dly_cycles),
        .expired_o (dly_expired)
    );

    // register writes
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            step_timing         <= 6'h00;
            load_current_select <= `BIM_CUR_NONE;
            dly_skip            <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `BIM_ADDR_TIMING) begin
                step_timing <= reg_wdata_i[5:0];
            end
            if (cfg_wr) begin
                load_current_select <= reg_wdata_i[`BIM_CUR_HI:0];
                dly_skip            <= reg_wdata_i[`BIM_CFG_DLYSKIP];
            end
        end
    end

    // register reads
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `BIM_ZERO8;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `BIM_ADDR_TIMING: reg_rdata_o <= {2'h0, step_timing};
                // R4: active flag read back
                `BIM_ADDR_CONFIG: reg_rdata_o <= {measurement_active, aborted, 2'h0,
                                                  dly_skip, load_current_select};
                `BIM_ADDR_SUPPLY: reg_rdata_o <= supply_result_code;
                `BIM_ADDR_OPEN:   reg_rdata_o <= open_result_code;
                `BIM_ADDR_LOADED: reg_rdata_o <= loaded_result_code;
                default:          reg_rdata_o <= `BIM_ZERO8;
            endcase
        end
    end

    // sequence state machine
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state              <= ST_IDLE;
            step               <= `BIM_STEP_SUPPLY;
            run_timing         <= 6'h00;
            run_current        <= `BIM_CUR_NONE;
            aborted            <= 1'b0;
            conv_start_o       <= 1'b0;
            conv_step_o        <= `BIM_STEP_SUPPLY;
            supply_result_code <= `BIM_ZERO8;
            open_result_code   <= `BIM_ZERO8;
            loaded_result_code <= `BIM_ZERO8;
        end else begin
            conv_start_o <= 1'b0;
            if (abort_req) begin
                // R6: abort stops and reports
                aborted <= 1'b1;
                if (measurement_active) begin
                    state              <= ST_IDLE;
                    supply_result_code <= `BIM_ABORT_CODE;
                    open_result_code   <= `BIM_ABORT_CODE;
                    loaded_result_code <= `BIM_ABORT_CODE;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        // R2: start latches settings
                        if (start_req) begin
                            state       <= ST_EVAL;
                            step        <= `BIM_STEP_SUPPLY;
                            run_timing  <= step_timing;
                            run_current <= reg_wdata_i[`BIM_CUR_HI:0];
                            aborted     <= 1'b0;
                        end
                    end
                    ST_EVAL: begin
                        // R1: skip, immediate or delayed
                        if (cur_tm == `BIM_TM_SKIP) begin
                            case (step)
                                `BIM_STEP_SUPPLY: supply_result_code <= `BIM_SKIP_CODE;
                                `BIM_STEP_OPEN:   open_result_code   <= `BIM_SKIP_CODE;
                                default:          loaded_result_code <= `BIM_SKIP_CODE;
                            endcase
                            if (step == `BIM_STEP_LOADED) begin
                                state <= ST_IDLE;
                            end
                            step <= step + 2'h1;
                        end else if (cur_tm == `BIM_TM_NOW) begin
                            state        <= ST_CONV;
                            conv_start_o <= 1'b1;
                            conv_step_o  <= step;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (dly_expired) begin
                            state        <= ST_CONV;
                            conv_start_o <= 1'b1;
                            conv_step_o  <= step;
                        end
                    end
                    ST_CONV: begin
                        if (conv_done_i) begin
                            case (step)
                                `BIM_STEP_SUPPLY: supply_result_code <= conv_data_i;
                                `BIM_STEP_OPEN:   open_result_code   <= conv_data_i;
                                default:          loaded_result_code <= conv_data_i;
                            endcase
                            // R4: active drops after last step
                            if (step == `BIM_STEP_LOADED) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_EVAL;
                            end
                            step <= step + 2'h1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // load current drive during the loaded step
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            load_current_o <= `BIM_CUR_NONE;
            load_enable_o  <= 1'b0;
        end else begin
            load_enable_o <= measurement_active && !abort_req && (step == `BIM_STEP_LOADED);
            // R5: reserved code drives no current
            if (run_current == `BIM_CUR_RESERVED) begin
                load_current_o <= `BIM_CUR_NONE;
            end else begin
                load_current_o <= run_current;
            end
        end
    end
endmodule // bim_sequencer

// ===== bim_sequencer_chk.sv
// assertion checker for the measurement sequencer
`timescale 1ns/1ps
`include "bim_defines.vh"
module bim_sequencer_chk #(
    parameter int SHORT_CYCLES = 20,
    parameter int LONG_CYCLES  = 50
) (
    input wire       ref_clk_i,
    input wire       rstn_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_wr_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       conv_start_o,
    input wire [1:0] conv_step_o,
    input wire       conv_done_i,
    input wire [7:0] conv_data_i,
    input wire [2:0] load_current_o,
    input wire       load_enable_o,
    input wire       measuring_o
);
    localparam int S_LO = SHORT_CYCLES - 10;
    localparam int S_HI = SHORT_CYCLES - 4;
    reg  [7:0] tm;
    reg  [2:0] cur;
    reg  [1:0] rt_loaded;
    wire       wr_cfg = reg_wr_i && reg_addr_i == `BIM_ADDR_CONFIG;
    wire       go     = wr_cfg && reg_wdata_i[7] && !reg_wdata_i[6];
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tm  <= 8'h00;
            cur <= 3'h0;
            rt_loaded <= 2'h0;
        end else begin
            if (go && !measuring_o) rt_loaded <= tm[1:0];
            if (reg_wr_i && reg_addr_i == `BIM_ADDR_TIMING) tm <= reg_wdata_i;
            if (go && !measuring_o) cur <= reg_wdata_i[2:0];
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence start_idle; go && !measuring_o; endsequence
    sequence short_wait; (!conv_start_o)[*8] ##[S_LO:S_HI] conv_start_o; endsequence
    start_run_a: assert property (start_idle |=> measuring_o)
        else $error("start write did not raise measuring");
    abort_stop_a: assert property (wr_cfg && reg_wdata_i[6] |=> !measuring_o)
        else $error("abort did not stop the sequence");
    now_step_a: assert property (go && !measuring_o && tm[5:4] == `BIM_TM_NOW
        |-> ##2 conv_start_o && conv_step_o == `BIM_STEP_SUPPLY) else $error("undelayed step late");
    short_delay_a: assert property (go && !measuring_o && tm[5:4] == `BIM_TM_SHORT
        |=> short_wait) else $error("short step delay wrong");
    start_refused_a: assert property (go && measuring_o && !conv_done_i
        && rt_loaded != `BIM_TM_SKIP |=> measuring_o) else $error("start during run disturbed it");
    busy_level_a: assert property (conv_start_o && !wr_cfg |-> measuring_o ##1 measuring_o)
        else $error("measuring low during conversion");
    cur_legal_a: assert property (load_current_o != `BIM_CUR_RESERVED)
        else $error("reserved load current driven");
    cur_latched_a: assert property (load_enable_o |-> load_current_o ==
        (cur == `BIM_CUR_RESERVED ? `BIM_CUR_NONE : cur)) else $error("load current wrong");
endmodule // bim_sequencer_chk
bind bim_sequencer bim_sequencer_chk #(
    .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_chk (.*);

// ===== bim_sequencer_bench.sv
// self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`include "bim_defines.vh"
module bim_sequencer_bench;
    localparam [20:0] SH = 21'h14;
    localparam [20:0] LG = 21'h32;
    reg        ref_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0;
    reg        reg_rd_i = 1'b0, conv_done_i = 1'b0;
    reg  [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, conv_data_i = 8'h00, i;
    wire [7:0] reg_rdata_o;
    wire [1:0] conv_step_o;
    wire [2:0] load_current_o;
    wire       conv_start_o, load_enable_o, measuring_o;
    int        errors = 0, checked = 0, cycles = 0, n;
    bim_sequencer #(
        .SHORT_CYCLES (SH),
        .LONG_CYCLES  (LG)
    ) u_bim_sequencer (
        .ref_clk_i      (ref_clk_i),
        .rstn_i         (rstn_i),
        .reg_addr_i     (reg_addr_i),
        .reg_wdata_i    (reg_wdata_i),
        .reg_wr_i       (reg_wr_i),
        .reg_rd_i       (reg_rd_i),
        .reg_rdata_o    (reg_rdata_o),
        .conv_start_o   (conv_start_o),
        .conv_step_o    (conv_step_o),
        .conv_done_i    (conv_done_i),
        .conv_data_i    (conv_data_i),
        .load_current_o (load_current_o),
        .load_enable_o  (load_enable_o),
        .measuring_o    (measuring_o)
    );
    initial forever #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors = errors + 1;
            give_verdict;
        end
    end
    // converter answers three cycles after each start
    initial forever begin
        @(posedge ref_clk_i);
        #1;
        if (conv_start_o === 1'b1) begin
            repeat (3) @(posedge ref_clk_i);
            #1 conv_data_i = 8'h40 + conv_step_o;
            conv_done_i = 1'b1;
            @(posedge ref_clk_i);
            #1 conv_data_i = 8'ha5;
            conv_done_i = 1'b0;
        end
    end
    task automatic check(input [7:0] seen, input [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write when rw is one, else read and compare
    task automatic acc(input rw, input [7:0] a, input [7:0] d);
        @(posedge ref_clk_i);
        #1 {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {rw, !rw, a, d};
        @(posedge ref_clk_i);
        #1 {reg_wr_i, reg_rd_i} = 2'b00;
        if (!rw) check(reg_rdata_o, d);
    endtask
    task automatic wait_idle;
        for (n = 0; n < 400 && measuring_o !== 1'b0; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_i);
        #1 rstn_i = 1'b1;
        for (i = 8'h0d; i < 8'h13; i++) acc(0, i, 8'h00);
        acc(1, `BIM_ADDR_TIMING, 8'h15);
        acc(0, `BIM_ADDR_TIMING, 8'h15);
        acc(1, `BIM_ADDR_CONFIG, 8'h83);
        acc(0, `BIM_ADDR_CONFIG, 8'h83);
        wait_idle;
        check({7'h00, n < 30}, 8'h01);
        for (i = 0; i < 3; i++) acc(0, `BIM_ADDR_SUPPLY + i, 8'h40 + i);
        acc(0, `BIM_ADDR_CONFIG, 8'h03);
        acc(1, `BIM_ADDR_TIMING, 8'h2c);
        acc(1, `BIM_ADDR_CONFIG, 8'h87);
        repeat (10) @(posedge ref_clk_i);
        acc(1, `BIM_ADDR_CONFIG, 8'h81);
        check({7'h00, measuring_o}, 8'h01);
        check({5'h00, load_current_o}, 8'h00);
        wait_idle;
        check({7'h00, n > SH + LG - 15 && n < SH + LG + 10}, 8'h01);
        acc(0, `BIM_ADDR_OPEN, 8'h41);
        acc(0, `BIM_ADDR_LOADED, 8'h00);
        acc(0, `BIM_ADDR_CONFIG, 8'h01);
        acc(1, `BIM_ADDR_TIMING, 8'h3f);
        acc(1, `BIM_ADDR_CONFIG, 8'h82);
        repeat (5) @(posedge ref_clk_i);
        acc(1, `BIM_ADDR_CONFIG, 8'h48);
        check({7'h00, measuring_o}, 8'h00);
        acc(0, `BIM_ADDR_CONFIG, 8'h48);
        for (i = 0; i < 3; i++) acc(0, `BIM_ADDR_SUPPLY + i, 8'hff);
        acc(1, `BIM_ADDR_TIMING, 8'h01);
        for (i = 0; i < 7; i++) begin
            acc(1, `BIM_ADDR_CONFIG, 8'h80 | i);
            acc(0, `BIM_ADDR_CONFIG, 8'h80 | i);
            acc(1, `BIM_ADDR_CONFIG, 8'h80 | i);
            check({7'h00, load_enable_o}, 8'h01);
            wait_idle;
            acc(0, `BIM_ADDR_SUPPLY, 8'h00);
            acc(0, `BIM_ADDR_LOADED, 8'h42);
        end
        give_verdict;
    end
endmodule // bim_sequencer_bench
